// file: src/aote_pkg.sv
// constants and types shared by the output timing engine
package aote_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_DIV = 4'h2;
    localparam logic [3:0] REG_DELAY = 4'h3;
    localparam logic [3:0] REG_COUNT = 4'h4;
    localparam logic [3:0] REG_TRIG = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    localparam logic [3:0] REG_DATA = 4'h7;
    localparam logic [3:0] REG_SWUPD = 4'h8;
    localparam logic [3:0] REG_CHANS = 4'h9;
    // ctrl bits (write one to act)
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_SW_TASK = 2;
    localparam int CTRL_SW_TRIG = 3;
    localparam int CTRL_CLEAR = 4;
    // mode register fields
    localparam int MODE_SMP_LSB = 0;
    localparam int MODE_EXT_TB = 2;
    localparam int MODE_EXT_CLK = 3;
    localparam int MODE_CLK_POL = 4;
    // trig register fields
    localparam int TRIG_SRC_LSB = 0;
    localparam int TRIG_FALL = 3;
    localparam int TRIG_EN = 4;
    localparam int TRIG_HOLD_EN = 5;
    localparam int TRIG_HOLD_LOW = 6;
    localparam int TRIG_HOLD_ANA = 7;
    // status bits
    localparam int ST_RUN = 0;
    localparam int ST_SW_TASK = 1;
    localparam int ST_UNDERFLOW = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_FULL = 4;
    localparam int ST_EMPTY = 5;
    localparam int ST_DONE = 6;
    // limits and reset values
    localparam logic [5:0] LIMIT_ONBOARD_CHANS = 6'h10;
    localparam logic [15:0] RST_DIV = 16'h0063;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [31:0] RST_COUNT = 32'h00000000;
    localparam logic [5:0] RST_CHANS = 6'h01;

    typedef enum logic [1:0] {
        SMP_FINITE = 2'b00,
        SMP_REGEN = 2'b01,
        SMP_ONBOARD = 2'b10,
        SMP_NOREGEN = 2'b11
    } aote_smp_t;

    typedef enum logic [2:0] {
        TSRC_SOFT = 3'b000,
        TSRC_TERM = 3'b001,
        TSRC_REF = 3'b010,
        TSRC_INSTART = 3'b011,
        TSRC_ANALOG = 3'b100
    } aote_tsrc_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_DELAY = 2'b10,
        ST_RUNNING = 2'b11
    } aote_state_t;
endpackage

// file: src/aote_engine.sv
// analog output timing engine: fifo, update clock, triggers, modes
//
// How it works
// - hardware-timed updates always come from buffered samples, never commands
// - software-timed task updates converters once per update command
// - only one simultaneous software-timed task may be active
// - hardware-timed start refused during software task, and the reverse
// - host words go into the onboard fifo; hardware-timed updates fed only from it
// - finite mode counts samples and stops at the programmed count
// - continuous modes run until a stop command
// - regeneration accepts host words whenever the fifo is not full, output never interrupted
// - onboard regeneration replays loaded fifo, refusing further host data
// - onboard regeneration with more than 16 channels is refused
// - non-regeneration never repeats; empty fifo at update flags underflow
// - each update pulse updates all task channels together
// - update clock on terminal is active high unless polarity inverted
// - update clock divides internal or external timebase; timebase not output
// - start on begin trigger, or software start when no trigger
// - internal clock inserts programmable delay before the first sample
// - digital start sources selectable, rising or falling edge
// - analog comparison source starts on its first selected edge
// - begin trigger on terminal is an active-high pulse
// - two output trigger actions: begin and hold
// - hold stops new samples; an update in progress completes
// - hold is level sensitive with selectable active level
// - external clock resumes on the second edge after hold; internal resumes at once
//
// The address map and the address-and-strobe port were left to the implementer.
module aote_engine
    import aote_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic host_ready_out,
    input wire logic ext_timebase_in,
    input wire logic ext_clock_in,
    input wire logic function_terminal_in,
    input wire logic input_stop_reference_trigger_in,
    input wire logic input_begin_trigger_in,
    input wire logic analog_compare_in,
    input wire logic output_hold_trigger_in,
    output logic [DATA_W-1:0] sample_out,
    output logic update_out,
    output logic output_update_clock_out,
    output logic output_begin_trigger_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // configuration
        aote_state_t st;
        aote_smp_t smp;
        logic ext_tb;
        logic ext_clk;
        logic clk_pol;
        logic [15:0] div;
        logic [15:0] delay;
        logic [31:0] count;
        logic [5:0] chans;
        logic [2:0] tsrc;
        logic fall;
        logic trig_en;
        logic hold_en;
        logic hold_low;
        logic hold_ana;
        // task and status flags
        logic sw_task;
        logic underflow;
        logic refused;
        logic done;
        // counters and fifo pointers
        logic [15:0] divcnt;
        logic [15:0] dlycnt;
        logic [31:0] done_cnt;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic [AW:0] loaded;
        logic locked;
        // synchronisers and edge history
        logic [2:0] s_tb;
        logic [2:0] s_clk;
        logic [2:0] s_term;
        logic [2:0] s_ref;
        logic [2:0] s_ist;
        logic [2:0] s_ana;
        logic [2:0] s_hold;
        logic tb_last;
        logic clk_last;
        logic trig_last;
        logic wait_edge;
        // registered outputs
        logic [DATA_W-1:0] sample;
        logic update;
        logic begin_pulse;
        logic [31:0] rdata;
    } aote_reg_t;

    aote_reg_t r;
    aote_reg_t next_r;
    logic [DATA_W-1:0] mem [DEPTH];

    // stable level once 2nd and 3rd sync stages agree
    function automatic logic settle(input logic [2:0] s, input logic last);
        settle = (s[1] == s[2]) ? s[2] : last;
    endfunction

    logic [AW:0] level;
    logic full;
    logic empty;
    logic hw_busy;
    logic push;
    logic tb_now;
    logic clk_now;
    logic trig_lvl;
    logic trig_edge;
    logic hold_lvl;
    logic held;
    logic tick;
    logic do_update;
    logic [AW:0] rp_next;
    logic stop_req;

    // pointers carry a spare bit so full and empty differ
    assign level = r.wp - r.rp;
    assign full = (level == (AW + 1)'(DEPTH));
    assign empty = (level == '0);
    assign hw_busy = (r.st != ST_IDLE);
    // stop overrides the sequencer so the flush sticks
    assign stop_req = wr_in && (addr_in == REG_CTRL) && wdata_in[CTRL_STOP];
    // onboard mode refuses host data once started
    assign host_ready_out = !full && !r.locked;
    assign push = wr_in && (addr_in == REG_DATA) && host_ready_out;
    assign tb_now = settle(r.s_tb, r.tb_last);
    assign clk_now = settle(r.s_clk, r.clk_last);

    // start source selection
    // a source change counts once two sync stages agree
    always_comb begin
        case (r.tsrc)
            TSRC_TERM: trig_lvl = settle(r.s_term, r.trig_last);
            TSRC_REF: trig_lvl = settle(r.s_ref, r.trig_last);
            TSRC_INSTART: trig_lvl = settle(r.s_ist, r.trig_last);
            TSRC_ANALOG: trig_lvl = settle(r.s_ana, r.trig_last);
            default: trig_lvl = 1'b0;
        endcase
    end
    // rising or falling edge of the chosen source
    assign trig_edge = r.fall ? (r.trig_last && !trig_lvl) : (!r.trig_last && trig_lvl);
    // hold is a level, polarity programmable
    assign hold_lvl = r.hold_ana ? r.s_ana[2] : r.s_hold[2];
    assign held = r.hold_en && (hold_lvl ^ r.hold_low);

    // update tick: divided timebase or external clock edge
    always_comb begin
        if (r.ext_clk) begin
            tick = clk_now && !r.clk_last;
        end else begin
            tick = (r.divcnt == '0) && (r.ext_tb ? (tb_now && !r.tb_last) : 1'b1);
        end
    end
    // hold masks ticks; external clock also waits a fresh edge
    assign do_update = (r.st == ST_RUNNING) && tick && !held && !r.wait_edge;
    // onboard replay: after the newest word go back to the oldest
    always_comb begin
        if (r.smp == SMP_ONBOARD && r.rp + 1'b1 == r.wp) begin
            rp_next = r.wp - r.loaded; // replay wraps to the first loaded word
        end else begin
            rp_next = r.rp + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.update = 1'b0;
        next_r.begin_pulse = 1'b0;
        next_r.rdata = '0;
        next_r.s_tb = {r.s_tb[1:0], ext_timebase_in};
        next_r.s_clk = {r.s_clk[1:0], ext_clock_in};
        next_r.s_term = {r.s_term[1:0], function_terminal_in};
        next_r.s_ref = {r.s_ref[1:0], input_stop_reference_trigger_in};
        next_r.s_ist = {r.s_ist[1:0], input_begin_trigger_in};
        next_r.s_ana = {r.s_ana[1:0], analog_compare_in};
        next_r.s_hold = {r.s_hold[1:0], output_hold_trigger_in};
        next_r.tb_last = tb_now;
        next_r.clk_last = clk_now;
        next_r.trig_last = trig_lvl;
        // an accepted host word advances the write side
        if (push) begin
            next_r.wp = r.wp + 1'b1;
            next_r.loaded = r.loaded + 1'b1;
        end
        // timebase divider
        if (!r.ext_clk && (!r.ext_tb || (tb_now && !r.tb_last))) begin
            next_r.divcnt = (r.divcnt == '0) ? r.div : r.divcnt - 1'b1;
        end
        // hold while external clock: wait for a new edge after release
        if (r.ext_clk && held) begin
            next_r.wait_edge = 1'b1;
        end else if (r.wait_edge && tick) begin
            next_r.wait_edge = 1'b0;
        end
        // register writes
        if (wr_in) begin
            case (addr_in)
                REG_MODE: if (!hw_busy) begin
                    next_r.smp = aote_smp_t'(wdata_in[MODE_SMP_LSB +: 2]);
                    next_r.ext_tb = wdata_in[MODE_EXT_TB];
                    next_r.ext_clk = wdata_in[MODE_EXT_CLK];
                    next_r.clk_pol = wdata_in[MODE_CLK_POL];
                end
                REG_DIV: next_r.div = wdata_in[15:0];
                REG_DELAY: next_r.delay = wdata_in[15:0];
                REG_COUNT: next_r.count = wdata_in;
                REG_CHANS: next_r.chans = wdata_in[5:0];
                REG_TRIG: begin
                    next_r.tsrc = wdata_in[TRIG_SRC_LSB +: 3];
                    next_r.fall = wdata_in[TRIG_FALL];
                    next_r.trig_en = wdata_in[TRIG_EN];
                    next_r.hold_en = wdata_in[TRIG_HOLD_EN];
                    next_r.hold_low = wdata_in[TRIG_HOLD_LOW];
                    next_r.hold_ana = wdata_in[TRIG_HOLD_ANA];
                end
                REG_SWUPD: if (r.sw_task) begin
                    next_r.sample = wdata_in[DATA_W-1:0];
                    next_r.update = 1'b1;
                end
                REG_CTRL: begin
                    if (wdata_in[CTRL_CLEAR]) begin
                        next_r.underflow = 1'b0;
                        next_r.refused = 1'b0;
                        next_r.done = 1'b0;
                    end
                    if (wdata_in[CTRL_SW_TASK]) begin
                        if (hw_busy || r.sw_task) begin
                            next_r.refused = 1'b1;
                        end else begin
                            next_r.sw_task = 1'b1;
                        end
                    end
                    if (wdata_in[CTRL_STOP]) begin
                        next_r.st = ST_IDLE;
                        next_r.sw_task = 1'b0;
                        next_r.locked = 1'b0;
                        next_r.rp = r.wp; // flush on stop
                        next_r.loaded = '0;
                    end else if (wdata_in[CTRL_START] && !hw_busy) begin
                        if (r.sw_task || (r.smp == SMP_ONBOARD &&
                                r.chans > LIMIT_ONBOARD_CHANS)) begin
                            next_r.refused = 1'b1;
                        end else begin
                            next_r.st = r.trig_en ? ST_ARMED : ST_DELAY;
                            next_r.dlycnt = r.delay;
                            next_r.done_cnt = '0;
                            next_r.done = 1'b0;
                            next_r.locked = (r.smp == SMP_ONBOARD);
                            next_r.begin_pulse = !r.trig_en;
                        end
                    end
                end
                default: ;
            endcase
        end
        // sequencer; a stop in this cycle suppresses it
        case (stop_req ? ST_IDLE : r.st)
            ST_ARMED: begin
                if (trig_edge || (wr_in && addr_in == REG_CTRL &&
                        wdata_in[CTRL_SW_TRIG] && r.tsrc == TSRC_SOFT)) begin
                    next_r.st = ST_DELAY;
                    next_r.begin_pulse = 1'b1;
                end
            end
            ST_DELAY: begin
                // delay only counts with the internal clock
                if (r.ext_clk || r.dlycnt == '0) begin
                    next_r.st = ST_RUNNING;
                end else begin
                    next_r.dlycnt = r.dlycnt - 1'b1;
                end
            end
            ST_RUNNING: begin
                if (do_update) begin
                    if (empty) begin
                        next_r.underflow = 1'b1;
                    end else begin
                        next_r.sample = mem[r.rp[AW-1:0]];
                        next_r.update = 1'b1;
                        if (r.smp == SMP_REGEN && !push) begin
                            // recirculate the word so the buffer repeats
                            next_r.wp = r.wp + 1'b1;
                        end
                        next_r.rp = rp_next;
                        next_r.done_cnt = r.done_cnt + 1'b1;
                        // finite mode: the last programmed sample ends the run
                        if (r.smp == SMP_FINITE && r.done_cnt + 32'h1 >= r.count) begin
                            next_r.st = ST_IDLE;
                            next_r.done = 1'b1;
                        end
                    end
                end
            end
            default: ;
        endcase
        // status readback
        // read data stands one cycle, zero otherwise
        if (rd_in) begin
            case (addr_in)
                REG_STATUS: begin
                    next_r.rdata[ST_RUN] = hw_busy;
                    next_r.rdata[ST_SW_TASK] = r.sw_task;
                    next_r.rdata[ST_UNDERFLOW] = r.underflow;
                    next_r.rdata[ST_REFUSED] = r.refused;
                    next_r.rdata[ST_FULL] = full;
                    next_r.rdata[ST_EMPTY] = empty;
                    next_r.rdata[ST_DONE] = r.done;
                end
                REG_MODE: next_r.rdata[4:0] = {r.clk_pol, r.ext_clk, r.ext_tb, r.smp};
                REG_DIV: next_r.rdata[15:0] = r.div;
                REG_DELAY: next_r.rdata[15:0] = r.delay;
                REG_COUNT: next_r.rdata = r.done_cnt;
                REG_CHANS: next_r.rdata[5:0] = r.chans;
                REG_TRIG: next_r.rdata[7:0] = {r.hold_ana, r.hold_low, r.hold_en,
                    r.trig_en, r.fall, r.tsrc};
                default: next_r.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // clear all, then load configuration defaults
            r <= '0;
            r.st <= ST_IDLE;
            r.div <= RST_DIV;
            r.delay <= RST_DELAY;
            r.count <= RST_COUNT;
            r.chans <= RST_CHANS;
        end else begin
            r <= next_r;
        end
    end

    // sample store, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[r.wp[AW-1:0]] <= wdata_in[DATA_W-1:0];
        end else if (r.smp == SMP_REGEN && do_update && !empty) begin
            // regeneration copies the outgoing word to the tail
            mem[r.wp[AW-1:0]] <= mem[r.rp[AW-1:0]];
        end
    end

    // outputs
    assign rdata_out = r.rdata;
    assign sample_out = r.sample;
    assign update_out = r.update;
    assign output_update_clock_out = r.update ^ r.clk_pol;
    assign output_begin_trigger_out = r.begin_pulse;
endmodule

// file: test/aote_engine_asserts.sv
// port checker for the output timing engine
module aote_engine_asserts
    import aote_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic [DATA_W-1:0] sample_out,
    input wire logic update_out,
    input wire logic output_update_clock_out,
    input wire logic output_begin_trigger_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pol, ten, sw, seen, first;
    logic [1:0] smp;
    logic [5:0] chn;
    logic [15:0] div, dly;
    logic [31:0] gap, sb;
    wire go = wr_in && addr_in == REG_CTRL && wdata_in[CTRL_START];
    wire big = smp == SMP_ONBOARD && chn > LIMIT_ONBOARD_CHANS;
    // shadow of what the bus configured
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pol <= 1'h0;
            ten <= 1'h0;
            sw <= 1'h0;
            smp <= 2'h0;
            chn <= RST_CHANS;
            div <= RST_DIV;
            dly <= RST_DELAY;
        end else if (wr_in) begin
            case (addr_in)
                REG_MODE: {pol, smp} <= {wdata_in[MODE_CLK_POL], wdata_in[1:0]};
                REG_TRIG: ten <= wdata_in[TRIG_EN];
                REG_DIV: div <= wdata_in[15:0];
                REG_DELAY: dly <= wdata_in[15:0];
                REG_CHANS: chn <= wdata_in[5:0];
                REG_CTRL: sw <= (sw | wdata_in[CTRL_SW_TASK]) & ~wdata_in[CTRL_STOP];
                default: ;
            endcase
        end
    end
    // cycles since the last update and since the begin pulse
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap <= 32'h0;
            sb <= 32'h0;
            seen <= 1'h0;
            first <= 1'h0;
        end else begin
            gap <= update_out ? 32'h1 : gap + 32'h1;
            sb <= output_begin_trigger_out ? 32'h0 : sb + 32'h1;
            seen <= seen | update_out;
            first <= output_begin_trigger_out | (first & ~update_out);
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    chk_upd_single: assert property (update_out |=> !update_out)
        else $error("update pulse longer than one cycle");
    chk_begin_single: assert property (output_begin_trigger_out |=> !output_begin_trigger_out)
        else $error("begin pulse longer than one cycle");
    chk_clk_polarity: assert property (output_update_clock_out == (update_out ^ pol))
        else $error("update clock polarity wrong");
    chk_sample_cause: assert property ($changed(sample_out) |-> update_out)
        else $error("sample changed without update");
    chk_upd_spacing: assert property (update_out && seen |-> gap > {16'h0, div})
        else $error("updates closer than divider period");
    chk_begin_cause: assert property (output_begin_trigger_out |-> $past(go) || ten)
        else $error("begin pulse without start or trigger");
    chk_soft_start: assert property (go && !ten && !sw && !big |=> output_begin_trigger_out)
        else $error("software start gave no begin pulse");
    chk_first_delay: assert property (update_out && first |-> sb >= {16'h0, dly})
        else $error("first sample before start delay");
    cov_update: cover property (update_out);
    cov_begin: cover property (output_begin_trigger_out);
    cov_first: cover property (output_begin_trigger_out ##[1:40] update_out);
endmodule

bind aote_engine aote_engine_asserts #(.DATA_W(DATA_W)) u_chk (
    .clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .sample_out, .update_out,
    .output_update_clock_out, .output_begin_trigger_out
);

// file: test/aote_out_model.sv
// plug-in output module model: latches every update
module aote_out_model
    import aote_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic clk_in,
    input wire logic update_in,
    input wire logic begin_in,
    input wire logic [DATA_W-1:0] sample_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] got[$];
    int n_upd = 0;
    int n_beg = 0;
    // all channels of the module follow the one shared update
    always @(posedge clk_in) begin
        if (update_in === 1'h1) begin
            got.push_back(sample_in);
            n_upd++;
        end
        if (begin_in === 1'h1) begin
            n_beg++;
        end
    end
endmodule

// file: test/testbench.sv
// self-checking bench for the output timing engine
module testbench
    import aote_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, resetn = 1'h0, wr_s = 1'h0, rd_s = 1'h0, hold = 1'h0, ext = 1'h0;
    logic [3:0] addr = 4'h0, tin = 4'h0;
    logic [31:0] wdata = 32'h0, r, rdata;
    logic rdy, upd, uclk, beg;
    logic [15:0] smp;
    logic [15:0] d[$];
    int n_errors = 0;
    int n_compared = 0;
    int k, f;

    aote_engine u_dut (
        .clk_in(clk_in), .resetn_in(resetn), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .host_ready_out(rdy),
        .ext_timebase_in(ext), .ext_clock_in(ext), .function_terminal_in(tin[0]),
        .input_stop_reference_trigger_in(tin[1]), .input_begin_trigger_in(tin[2]),
        .analog_compare_in(tin[3]), .output_hold_trigger_in(hold), .sample_out(smp),
        .update_out(upd), .output_update_clock_out(uclk), .output_begin_trigger_out(beg)
    );
    aote_out_model u_mdl (.clk_in(clk_in), .update_in(upd), .begin_in(beg), .sample_in(smp));

    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bus cycles, with an idle cycle after each
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'h1;
        @(posedge clk_in);
        wr_s <= 1'h0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [3:0] a);
        addr <= a;
        rd_s <= 1'h1;
        @(posedge clk_in);
        rd_s <= 1'h0;
        #1;
        r = rdata;
        @(posedge clk_in);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wait_upd(input int n);
        for (int i = 0; i < 3000 && u_mdl.n_upd < n; i++) begin
            @(posedge clk_in);
        end
    endtask

    // stop, clear flags and set a new mode
    task automatic fresh(input logic [31:0] m);
        wr(REG_CTRL, 32'h12);
        wr(REG_MODE, m);
        wr(REG_TRIG, 32'h0);
        u_mdl.got.delete();
        u_mdl.n_upd = 0;
        u_mdl.n_beg = 0;
        d.delete();
    endtask

    task automatic load(input int n);
        for (int i = 0; i < n; i++) begin
            d.push_back(16'($urandom));
            wr(REG_DATA, {16'h0, d[$]});
        end
    endtask

    initial begin
        cyc(20000);
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(64404));
        cyc(20);
        resetn <= 1'h1;
        @(posedge clk_in);
        wr(4'hF, 32'hFFFFFFFF);
        rd(REG_STATUS);
        chk("status", r, 32'h20);
        // finite run from a full fifo, extra word dropped
        fresh(32'h10);
        wr(REG_DIV, 32'h1);
        wr(REG_DELAY, $urandom_range(15));
        wr(REG_COUNT, 32'h40);
        load(64);
        wr(REG_DATA, 32'h5A5A);
        chk("ready", rdy, 1'h0);
        rd(REG_STATUS);
        chk("full", r[ST_FULL], 1'h1);
        wr(REG_CTRL, 32'h1);
        wait_upd(64);
        cyc(30);
        chk("nupd", u_mdl.n_upd, 64);
        chk("nbeg", u_mdl.n_beg, 1);
        for (int i = 0; i < 64; i++) begin
            chk("sample", u_mdl.got[i], d[i]);
        end
        rd(REG_STATUS);
        chk("done", r, 32'h60);
        rd(REG_COUNT);
        chk("count", r, 32'h40);
        chk("clkpol", uclk, 1'h1);
        // regeneration, hold at either level, stop
        fresh(32'h1);
        load(3);
        wr(REG_CTRL, 32'h1);
        wait_upd(7);
        for (int i = 0; i < 7; i++) begin
            chk("regen", u_mdl.got[i], d[i % 3]);
        end
        for (int lv = 0; lv < 2; lv++) begin
            wr(REG_TRIG, 32'h20 | (lv << 6));
            hold <= 1'(lv == 0);
            cyc(10);
            k = u_mdl.n_upd;
            cyc(40);
            chk("held", u_mdl.n_upd, k);
            hold <= 1'(lv != 0);
            cyc(20);
            chk("resume", u_mdl.n_upd > k, 1'h1);
        end
        wr(REG_CTRL, 32'h2);
        k = u_mdl.n_upd;
        cyc(40);
        chk("stopped", u_mdl.n_upd, k);
        // onboard regeneration: 17 channels refused, 16 run
        for (int c = 17; c > 15; c--) begin
            fresh(32'h2);
            wr(REG_CHANS, c);
            load(2);
            wr(REG_CTRL, 32'h1);
            rd(REG_STATUS);
            chk("refused", r[ST_REFUSED], 1'(c == 17));
            chk("locked", rdy, 1'(c == 17));
        end
        wr(REG_DATA, 32'h1234);
        wait_upd(5);
        chk("onboard", u_mdl.got[4], d[0]);
        // non-regeneration runs dry
        fresh(32'h3);
        load(1);
        wr(REG_CTRL, 32'h1);
        cyc(30);
        rd(REG_STATUS);
        chk("underflow", r[ST_UNDERFLOW], 1'h1);
        // every start source except the software trigger on a random edge
        for (int s = 1; s < 5; s++) begin
            f = $urandom_range(1);
            fresh(32'h0);
            wr(REG_COUNT, 32'h1);
            load(1);
            tin[s-1] <= 1'(f);
            wr(REG_TRIG, 32'h10 | (f << 3) | s);
            wr(REG_CTRL, 32'h1);
            cyc(10);
            chk("armed", u_mdl.n_beg, 0);
            tin[s-1] <= 1'(f == 0);
            wait_upd(1);
            chk("trig", u_mdl.n_beg, 1);
            tin <= 4'h0;
        end
        // external update clock, then external timebase with no division
        for (int m = 0; m < 2; m++) begin
            wr(REG_DIV, 32'h0);
            fresh(m ? 32'h4 : 32'h8);
            wr(REG_COUNT, 32'h2);
            load(2);
            wr(REG_CTRL, 32'h1);
            repeat (4) begin
                cyc(20);
                ext <= ~ext;
            end
            cyc(20);
            chk("extupd", u_mdl.n_upd, 2);
            chk("extsmp", u_mdl.got[1], d[1]);
        end
        // software-timed task excludes others
        fresh(32'h0);
        wr(REG_CTRL, 32'h4);
        rd(REG_STATUS);
        chk("swtask", r[ST_SW_TASK], 1'h1);
        wr(REG_CTRL, 32'h4);
        rd(REG_STATUS);
        chk("second", r[ST_REFUSED], 1'h1);
        wr(REG_CTRL, 32'h10);
        wr(REG_CTRL, 32'h1);
        rd(REG_STATUS);
        chk("hwrefused", r[ST_REFUSED:ST_RUN], 4'hA);
        f = $urandom;
        wr(REG_SWUPD, f);
        cyc(5);
        chk("swupd", u_mdl.n_upd, 1);
        chk("swval", u_mdl.got[0], 16'(f));
        conclude();
    end
endmodule
